// file: hw/pit_pkg.sv
// Notes on behaviour
// R1: Terminals map onto fixed word and bit addresses
// R2: Knob positions load as BCD 0 to 200
// R3: Filter constant selectable 1 to 128 ms; word 001 here uses a 0.1 to 56 ms table
// R4: Word 000 delay set to set+0.5 ms; here it is set to set+0.1 ms
// R5: Response is hardware, filter and scan time
// R6: Two or four interrupt terminals, bits 3-6
// R7: Each interrupt input direct or counter mode
// R8: Direct mode interrupts within 0.3 ms
// R9: Counter mode interrupts when count hits set value
// R10: Unconfigured interrupt bits act as plain inputs
// R11: Software spaces refreshes 1.3 ms apart
// R12: Interrupt terminals double as quick-response inputs
// R13: Quick inputs latch pulses of 0.2 ms
// R14: Timer 0.5-319968 ms in 0.1 ms steps
// R15: One-shot mode interrupts once then stops
// R16: Scheduled mode interrupts and reloads every timeout
// R17: Filter passes level only after stable time
package pit_pkg;
	// Time base: one tick is 0.1 ms
	localparam int CLK_NS   = 100;
	localparam int TICK_NS  = 100_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int TDIV_W   = 10;
	// Terminal layout
	localparam int IN_W     = 12;
	localparam int OUT_W    = 8;
	localparam int IRQ_MAX  = 4;
	localparam int IRQ_BASE = 3;
	localparam int CNT_W    = 16;
	localparam int FCNT_W   = 11;
	localparam int TMR_W    = 22;
	localparam int ST_W     = 5;
	localparam int ST_TMR   = 4;
	localparam int TC_RUN   = 0;
	localparam int TC_ONE   = 1;
	// Word indexes; byte address is four times the index
	localparam logic [7:0] IDX_IN0   = 8'h00;
	localparam logic [7:0] IDX_IN1   = 8'h01;
	localparam logic [7:0] IDX_OUT0  = 8'h0a;
	localparam logic [7:0] IDX_OUT1  = 8'h0b;
	localparam logic [7:0] IDX_FILT  = 8'h80;
	localparam logic [7:0] IDX_MODE  = 8'h81;
	localparam logic [7:0] IDX_STAT  = 8'h82;
	localparam logic [7:0] IDX_MASK  = 8'h83;
	localparam logic [7:0] IDX_TPER  = 8'h84;
	localparam logic [7:0] IDX_TCTL  = 8'h85;
	localparam logic [7:0] IDX_SV    = 8'h88;
	localparam logic [7:0] IDX_CNT   = 8'h8c;
	localparam logic [7:0] IDX_KNOB0 = 8'hfa;
	localparam logic [7:0] IDX_KNOB1 = 8'hfb;
	// Interval timer limits in ticks
	localparam logic [TMR_W-1:0] TMR_MIN = 22'h00_0005;
	localparam logic [TMR_W-1:0] TMR_MAX = 22'h30_d2c0;
	// Knob scaling
	localparam logic [7:0]  KNOB_MAX = 8'hc8;
	localparam logic [15:0] KNOB_TOP = 16'h0200;
	localparam logic [7:0]  DEC_HUND = 8'h64;
	localparam logic [7:0]  DEC_TEN  = 8'h0a;
	// Filter ticks: word 000 shifts the 1 ms base, word 001 uses a table
	localparam logic [FCNT_W-1:0] FILT0_BASE = 11'h00a;
	localparam logic [7:0][FCNT_W-1:0] FILT1_TICKS = {
		11'h230, 11'h118, 11'h08c, 11'h046,
		11'h023, 11'h012, 11'h008, 11'h001};

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_DIRECT = 2'h1,
		MODE_COUNT  = 2'h2,
		MODE_QUICK  = 2'h3
	} pit_mode_t;
	typedef pit_mode_t [IRQ_MAX-1:0] pit_modes_t;

	// Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [9:0]  adr;
		logic [31:0] dat;
	} pit_wb_req_t;

	// Whole state of the block
	typedef struct packed {
		logic                           ack;
		logic [31:0]                    rdat;
		logic [OUT_W-1:0]               out0;
		logic [OUT_W-1:0]               out1;
		logic [2:0]                     fsel;
		pit_modes_t                     mode;
		logic [ST_W-1:0]                stat;
		logic [ST_W-1:0]                mask;
		logic [TMR_W-1:0]               tper;
		logic [TMR_W-1:0]               tcnt;
		logic                           trun;
		logic                           tone;
		logic [TDIV_W-1:0]              tdiv;
		logic [IRQ_MAX-1:0][CNT_W-1:0]  sv;
		logic [IRQ_MAX-1:0][CNT_W-1:0]  cnt;
		logic [IRQ_MAX-1:0]             prev;
		logic [IRQ_MAX-1:0]             qlat;
		logic [2*IN_W-1:0]              filt;
		logic [2*IN_W-1:0][FCNT_W-1:0]  fcnt;
		logic [15:0]                    knob0;
		logic [15:0]                    knob1;
	} pit_state_t;

	localparam pit_state_t ST_RESET = '0;
endpackage : pit_pkg

// file: hw/pit_top.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module pit_top #(
	parameter int NUM_IRQ  = pit_pkg::IRQ_MAX,
	parameter int TICK_CYC = pit_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// Wishbone slave
	input  wire pit_pkg::pit_wb_req_t          wb_i,
	output logic                               ack_o,
	output logic [31:0]                        dat_o,
	// Field terminals and knobs
	input  wire logic [pit_pkg::IN_W-1:0]      in0_i,
	input  wire logic [pit_pkg::IN_W-1:0]      in1_i,
	input  wire logic [7:0]                    knob0_i,
	input  wire logic [7:0]                    knob1_i,
	output logic [pit_pkg::OUT_W-1:0]          out0_o,
	output logic [pit_pkg::OUT_W-1:0]          out1_o,
	// Interrupt to the program executor
	output logic                               irq_o
);
	import pit_pkg::*;

	pit_state_t          st_q;
	pit_state_t          st_d;
	logic [2*IN_W-1:0]   raw;
	logic [IRQ_MAX-1:0]  rise;
	logic                tick;
	logic                req;
	logic                wr;
	logic                rd;
	logic                tout;
	logic [7:0]          idx;
	logic [31:0]         bmask;
	logic [31:0]         wdat;
	logic [31:0]         rdat;
	logic [IN_W-1:0]     view0;
	logic [FCNT_W-1:0]   lim0;
	logic [FCNT_W-1:0]   lim1;
	logic [TMR_W-1:0]    tlim;
	logic [ST_W-1:0]     ev;
	logic [ST_W-1:0]     clr;

	////////////////////////////////////////////////////////////////////
	// Knob position to BCD, clamped at the top of the scale
	function automatic logic [15:0] knob_bcd(input logic [7:0] pos);
		logic [7:0] v;
		logic [7:0] h;
		logic [7:0] r;
		logic [7:0] t;
		logic [7:0] u;
		v = (pos > KNOB_MAX) ? KNOB_MAX : pos;
		h = v / DEC_HUND;
		r = v % DEC_HUND;
		t = r / DEC_TEN;
		u = r % DEC_TEN;
		return {4'h0, h[3:0], t[3:0], u[3:0]};
	endfunction : knob_bcd

	////////////////////////////////////////////////////////////////////
	// Shared decode
	assign raw   = {in1_i, in0_i};
	assign rise  = raw[IRQ_BASE +: IRQ_MAX] & ~st_q.prev;
	assign idx   = wb_i.adr[9:2];
	assign req   = wb_i.cyc & wb_i.stb & ~st_q.ack;
	assign wr    = wb_i.cyc & wb_i.stb & wb_i.we & st_q.ack;
	assign rd    = req & ~wb_i.we;
	assign tick  = st_q.tdiv == TDIV_W'(TICK_CYC - 1);
	assign lim0  = FILT0_BASE << st_q.fsel; // R4
	assign lim1  = FILT1_TICKS[st_q.fsel]; // R3
	// Never time out below the shortest period, even before setup
	assign tlim  = (st_q.tper < TMR_MIN) ? TMR_MIN : st_q.tper; // R14
	assign bmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}},
	                {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
	// Unselected byte lanes keep the register's present value
	assign wdat  = (wb_i.dat & bmask) | (rdat & ~bmask);

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		st_d  = st_q;
		ev    = '0;
		clr   = '0;
		tout  = 1'b0;
		rdat  = '0;
		view0 = st_q.filt[IN_W-1:0];

		// Divider for the 0.1 ms tick
		st_d.tdiv = tick ? '0 : st_q.tdiv + 1'b1;

		// Stability filter, one counter per terminal
		for (int i = 0; i < 2*IN_W; i++) begin
			if (raw[i] == st_q.filt[i]) begin
				st_d.fcnt[i] = '0; // R17
			end else if (tick) begin
				if (st_q.fcnt[i] == ((i < IN_W) ? lim0 : lim1)) begin
					st_d.filt[i] = raw[i]; // R17 R3 R5
					st_d.fcnt[i] = '0;
				end else begin
					st_d.fcnt[i] = st_q.fcnt[i] + 1'b1;
				end
			end
		end

		// Interrupt-capable terminals; unused ones stay filtered inputs
		for (int j = 0; j < NUM_IRQ; j++) begin // R6
			st_d.prev[j] = raw[IRQ_BASE + j];
			case (st_q.mode[j]) // R7 R10
				MODE_DIRECT: begin
					// Raw edge, no filter: answers in one clock
					ev[j] = rise[j]; // R8
				end
				MODE_COUNT: begin
					if (rise[j]) begin
						if (CNT_W'(st_q.cnt[j] + 1'b1) == st_q.sv[j]) begin
							ev[j]        = 1'b1; // R9
							st_d.cnt[j] = '0;
						end else begin
							st_d.cnt[j] = st_q.cnt[j] + 1'b1;
						end
					end
				end
				MODE_QUICK: begin
					view0[IRQ_BASE + j] = st_q.qlat[j] | raw[IRQ_BASE + j]; // R12
				end
				default: begin
				end
			endcase
		end

		// Interval timer counts ticks up to the period
		if (tick && st_q.trun) begin
			if (st_q.tcnt >= tlim - 1'b1) begin
				tout         = 1'b1;
				ev[ST_TMR]   = 1'b1;
				st_d.tcnt    = '0; // R16
				if (st_q.tone) begin
					st_d.trun = 1'b0; // R15
				end
			end else begin
				st_d.tcnt = st_q.tcnt + 1'b1;
			end
		end

		// Register read mux
		if (idx == IDX_IN0) begin
			rdat = 32'(view0); // R1
		end else if (idx == IDX_IN1) begin
			rdat = 32'(st_q.filt[2*IN_W-1:IN_W]); // R1
		end else if (idx == IDX_OUT0) begin
			rdat = 32'(st_q.out0);
		end else if (idx == IDX_OUT1) begin
			rdat = 32'(st_q.out1);
		end else if (idx == IDX_FILT) begin
			rdat = 32'(st_q.fsel);
		end else if (idx == IDX_MODE) begin
			rdat = 32'(st_q.mode);
		end else if (idx == IDX_STAT) begin
			rdat = 32'(st_q.stat);
		end else if (idx == IDX_MASK) begin
			rdat = 32'(st_q.mask);
		end else if (idx == IDX_TPER) begin
			rdat = 32'(st_q.tper);
		end else if (idx == IDX_TCTL) begin
			rdat[TC_RUN] = st_q.trun;
			rdat[TC_ONE] = st_q.tone;
		end else if (idx[7:2] == IDX_SV[7:2]) begin
			rdat = 32'(st_q.sv[idx[1:0]]);
		end else if (idx[7:2] == IDX_CNT[7:2]) begin
			rdat = 32'(st_q.cnt[idx[1:0]]);
		end else if (idx == IDX_KNOB0) begin
			rdat = 32'(st_q.knob0);
		end else if (idx == IDX_KNOB1) begin
			rdat = 32'(st_q.knob1);
		end

		// Bus answer: one-cycle ack, data registered with it
		st_d.ack = req;
		if (rd) begin
			st_d.rdat = rdat;
		end

		// Register writes; later than the timer so software wins
		if (wr) begin
			if (idx == IDX_OUT0) begin
				st_d.out0 = wdat[OUT_W-1:0]; // R1
			end else if (idx == IDX_OUT1) begin
				st_d.out1 = wdat[OUT_W-1:0]; // R1
			end else if (idx == IDX_FILT) begin
				st_d.fsel = wdat[2:0]; // R3
			end else if (idx == IDX_MODE) begin
				st_d.mode = pit_modes_t'(wdat[2*IRQ_MAX-1:0]); // R7
			end else if (idx == IDX_STAT) begin
				clr = wb_i.dat[ST_W-1:0] & bmask[ST_W-1:0];
			end else if (idx == IDX_MASK) begin
				st_d.mask = wdat[ST_W-1:0];
			end else if (idx == IDX_TPER) begin
				if (wdat[TMR_W-1:0] < TMR_MIN) begin
					st_d.tper = TMR_MIN; // R14
				end else if (wdat[TMR_W-1:0] > TMR_MAX) begin
					st_d.tper = TMR_MAX; // R14
				end else begin
					st_d.tper = wdat[TMR_W-1:0];
				end
			end else if (idx == IDX_TCTL) begin
				// Any control write restarts the period from zero
				st_d.trun = wdat[TC_RUN];
				st_d.tone = wdat[TC_ONE];
				st_d.tcnt = '0;
			end else if (idx[7:2] == IDX_SV[7:2]) begin
				st_d.sv[idx[1:0]]  = wdat[CNT_W-1:0]; // R9
				st_d.cnt[idx[1:0]] = '0;
			end
		end

		// Quick latches: a read of word 000 clears, a new edge wins
		if (rd && idx == IDX_IN0) begin
			st_d.qlat = '0;
		end
		for (int k = 0; k < NUM_IRQ; k++) begin
			if (st_q.mode[k] == MODE_QUICK && rise[k]) begin
				st_d.qlat[k] = 1'b1; // R13
			end
		end

		// Sticky status: set beats a write-one clear
		st_d.stat = (st_q.stat & ~clr) | ev;

		// Knob words follow the knobs continuously
		st_d.knob0 = knob_bcd(knob0_i); // R2
		st_d.knob1 = knob_bcd(knob1_i); // R2
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops; level interrupt is the OR of status AND mask
	assign ack_o  = st_q.ack;
	assign dat_o  = st_q.rdat;
	assign out0_o = st_q.out0;
	assign out1_o = st_q.out1;
	assign irq_o  = |(st_q.stat & st_q.mask);

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_bus_req;
		wb_i.cyc && wb_i.stb && !ack_o;
	endsequence
	sequence s_bus_ans;
		ack_o ##1 !ack_o;
	endsequence

	a_bus_ack_once: assert property (s_bus_req |=> s_bus_ans)
		else $error("bus ack not a single cycle");

	a_direct_irq: assert property ( // R8
		st_q.mode[0] == MODE_DIRECT && rise[0] |=> st_q.stat[0])
		else $error("direct edge did not set status");

	a_count_hit: assert property ( // R9
		st_q.mode[1] == MODE_COUNT && rise[1] && !wr &&
		CNT_W'(st_q.cnt[1] + 1'b1) == st_q.sv[1]
		|=> st_q.stat[1] && st_q.cnt[1] == '0)
		else $error("counter hit missed");

	a_plain_quiet: assert property ( // R10
		st_q.mode[0] == MODE_NORMAL && !st_q.stat[0] |=> !st_q.stat[0])
		else $error("plain input raised status");

	a_quick_catch: assert property ( // R13
		st_q.mode[2] == MODE_QUICK && rise[2] |=> st_q.qlat[2])
		else $error("quick pulse not latched");

	a_quick_hold: assert property ( // R13
		st_q.qlat[2] && !(rd && idx == IDX_IN0) |=> st_q.qlat[2])
		else $error("quick latch lost without read");

	a_tmr_min: assert property ( // R14
		tout |-> st_q.tcnt >= TMR_MIN - 1'b1)
		else $error("timer period below minimum");

	a_oneshot_stop: assert property ( // R15
		tout && st_q.tone && !wr |=> !st_q.trun && st_q.stat[ST_TMR])
		else $error("one-shot timer kept running");

	a_sched_reload: assert property ( // R16
		tout && !st_q.tone && !wr
		|=> st_q.trun && st_q.tcnt == '0 && st_q.stat[ST_TMR])
		else $error("scheduled timer did not reload");

	a_filt_stable: assert property ( // R17
		st_q.filt[0] != $past(st_q.filt[0])
		|-> $past(st_q.fcnt[0]) == $past(lim0) && $past(tick))
		else $error("filter passed an unstable level");

	a_knob_top: assert property ( // R2
		knob0_i >= KNOB_MAX |=> st_q.knob0 == KNOB_TOP)
		else $error("knob word not clamped at 200");

	////////////////////////////////////////////////////////////////////
	// Register and status invariants
	a_out_hold: assert property ( // R1
		!(wr && idx == IDX_OUT0) |=> $stable(out0_o))
		else $error("output word changed without a write");

	a_mode_hold: assert property ( // R7
		!(wr && idx == IDX_MODE) |=> $stable(st_q.mode))
		else $error("input modes changed without a write");

	a_stat_sticky: assert property (
		!(wr && idx == IDX_STAT)
		|=> (st_q.stat & $past(st_q.stat)) == $past(st_q.stat))
		else $error("status bit dropped without a clear");

	a_stat_clear: assert property (
		wr && idx == IDX_STAT && wb_i.sel[0] && wb_i.dat[0] && !ev[0]
		|=> !st_q.stat[0])
		else $error("write-one clear did not clear status");

	a_ack_no_req: assert property (
		!(wb_i.cyc && wb_i.stb) |=> !ack_o)
		else $error("ack without a request");

	a_tper_range: assert property ( // R14
		st_q.tper == '0 ||
		(st_q.tper >= TMR_MIN && st_q.tper <= TMR_MAX))
		else $error("timer period outside its range");

	a_knob_digits: assert property ( // R2
		st_q.knob0[3:0] <= 4'h9 && st_q.knob0[7:4] <= 4'h9 &&
		st_q.knob0 <= KNOB_TOP)
		else $error("knob word not valid BCD");

	////////////////////////////////////////////////////////////////////
	// Datapath steps
	a_filt_hold: assert property ( // R17
		raw[0] == st_q.filt[0]
		|=> st_q.filt[0] == $past(st_q.filt[0]) && st_q.fcnt[0] == '0)
		else $error("filter moved while input matched");

	a_filt_count: assert property ( // R3
		raw[0] != st_q.filt[0] && !tick
		|=> st_q.fcnt[0] == $past(st_q.fcnt[0]))
		else $error("filter counted between ticks");

	a_count_step: assert property ( // R9
		st_q.mode[1] == MODE_COUNT && rise[1] && !wr &&
		CNT_W'(st_q.cnt[1] + 1'b1) != st_q.sv[1]
		|=> st_q.cnt[1] == CNT_W'($past(st_q.cnt[1]) + 1'b1))
		else $error("counter missed a pulse");

	a_quick_clear: assert property ( // R12
		rd && idx == IDX_IN0 && !rise[2] |=> !st_q.qlat[2])
		else $error("quick latch not cleared by read");

	a_tmr_idle: assert property ( // R15
		!st_q.trun |=> !$rose(st_q.stat[ST_TMR]))
		else $error("stopped timer raised status");

	a_tmr_step: assert property ( // R16
		tick && st_q.trun && !tout && !wr
		|=> st_q.tcnt == $past(st_q.tcnt) + 1'b1)
		else $error("timer missed a tick");
endmodule : pit_top
`default_nettype wire

// file: testbench/pit_field_model.sv
`timescale 1ns/100ps
`default_nettype none
// Field side: raw terminals, knobs and the executor's interrupt count
module pit_field_model (
	// Clock and interrupt line
	input  wire logic                clk_i,
	input  wire logic                irq_i,
	// Terminals and knobs
	output logic [pit_pkg::IN_W-1:0] in0_o,
	output logic [pit_pkg::IN_W-1:0] in1_o,
	output logic [7:0]               knob0_o,
	output logic [7:0]               knob1_o,
	// Interrupts taken by the executor
	output logic [7:0]               irq_cnt_o
);
	import pit_pkg::*;
	logic irq_q;
	////////////////////////////////////////////////
	// Field devices hold every line driven, never float
	initial begin
		in0_o = '0;
		in1_o = '0;
		knob0_o = '0;
		knob1_o = '0;
		irq_cnt_o = '0;
		irq_q = 1'b0;
	end
	// Executor enters its routine on each rising level; it never
	// refreshes I/O from there, so no spacing hazard arises
	always @(posedge clk_i) begin
		irq_q <= irq_i;
		if (irq_i && !irq_q) begin
			irq_cnt_o <= irq_cnt_o + 8'h01;
		end
	end
	// Static tasks: an automatic index is unsafe in a deferred write
	task pulse(input int b, input int n);
		in0_o[b] <= 1'b1;
		repeat (n) @(posedge clk_i);
		in0_o[b] <= 1'b0;
	endtask : pulse
	task set_words(input logic [IN_W-1:0] a, input logic [IN_W-1:0] b);
		in0_o <= a;
		in1_o <= b;
	endtask : set_words
	task set_knobs(input logic [7:0] a, input logic [7:0] b);
		knob0_o <= a;
		knob1_o <= b;
	endtask : set_knobs
endmodule : pit_field_model
`default_nettype wire

// file: testbench/plc_input_interrupt_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module plc_input_interrupt_timer_tb;
	import pit_pkg::*;
	logic             clk_i;
	logic             rst_i;
	logic             ack_o;
	logic             irq_o;
	pit_wb_req_t      wb_q;
	logic [31:0]      dat_o;
	logic [31:0]      rd;
	logic [IN_W-1:0]  in0;
	logic [IN_W-1:0]  in1;
	logic [7:0]       k0;
	logic [7:0]       k1;
	logic [7:0]       icnt;
	logic [OUT_W-1:0] out0_o;
	logic [OUT_W-1:0] out1_o;
	int               miscompares = 0;
	int               num_checks = 0;
	int               cyc = 0;
	////////////////////////////////////////////////
	// Short tick keeps the longest filter run near 13k cycles
	pit_top #(.NUM_IRQ(4), .TICK_CYC(10)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .ack_o(ack_o),
		.dat_o(dat_o), .in0_i(in0), .in1_i(in1), .knob0_i(k0),
		.knob1_i(k1), .out0_o(out0_o), .out1_o(out1_o), .irq_o(irq_o));
	pit_field_model fm_u (.clk_i(clk_i), .irq_i(irq_o), .in0_o(in0),
		.in1_o(in1), .knob0_o(k0), .knob1_o(k1), .irq_cnt_o(icnt));
	// Clock and cycle count
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc <= cyc + 1;
	////////////////////////////////////////////////
	// Classic single cycle; waits for ack, no latency assumed
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] d);
		wb_q <= '{1'b1, 1'b1, w, 4'hf, {i, 2'h0}, d};
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		wb_q <= '0;
		@(posedge clk_i);
	endtask : bus
	task automatic rchk(input logic [7:0] i, input logic [31:0] e);
		bus(1'b0, i, '0);
		`CHK(rd, e)
	endtask : rchk
	task automatic wait_to(input int t);
		while (cyc < t) @(posedge clk_i);
	endtask : wait_to
	task automatic t_basic();
		bus(1'b1, IDX_OUT0, 32'h0000_00a5);
		bus(1'b1, IDX_OUT1, 32'h0000_003c);
		`CHK({out1_o, out0_o}, 16'h3ca5)
		rchk(IDX_OUT0, 32'h0000_00a5);
		rchk(8'h40, 32'h0000_0000);
		fm_u.set_knobs(8'hff, 8'h96);
		repeat (3) @(posedge clk_i);
		rchk(IDX_KNOB0, 32'h0000_0200);
		rchk(IDX_KNOB1, 32'h0000_0150);
	endtask : t_basic
	// Alternate levels so each select sees a fresh edge
	task automatic t_filter();
		int lo[8] = '{1, 7, 15, 30, 60, 120, 240, 500};
		int hi[8] = '{3, 15, 25, 45, 90, 180, 350, 700};
		int t0;
		logic v;
		bus(1'b1, IDX_FILT, '0);
		fm_u.pulse(0, 60);
		repeat (150) @(posedge clk_i);
		rchk(IDX_IN0, 32'h0000_0000);
		for (int s = 0; s < 8; s++) begin
			v = ~s[0];
			bus(1'b1, IDX_FILT, 32'(s));
			fm_u.set_words({11'h000, v}, {11'h000, v});
			t0 = cyc;
			wait_to(t0 + lo[s] * 10 - 6);
			bus(1'b0, IDX_IN1, '0);
			`CHK(rd[0], ~v)
			wait_to(t0 + hi[s] * 10 + 8);
			bus(1'b0, IDX_IN1, '0);
			`CHK(rd[0], v)
			wait_to(t0 + (100 << s) - 12);
			bus(1'b0, IDX_IN0, '0);
			`CHK(rd[0], ~v)
			wait_to(t0 + (100 << s) + 40);
			bus(1'b0, IDX_IN0, '0);
			`CHK(rd[0], v)
		end
	endtask : t_filter
	// Input j0 direct, j1 counter, j2 quick, j3 plain
	task automatic t_inputs();
		bus(1'b1, IDX_FILT, '0);
		bus(1'b1, IDX_MASK, 32'h0000_001f);
		bus(1'b1, IDX_MODE, 32'h0000_0039);
		bus(1'b1, IDX_SV + 8'h01, 32'h0000_0003);
		fm_u.pulse(3, 2);
		repeat (3) @(posedge clk_i);
		`CHK({irq_o, icnt}, 9'h101)
		rchk(IDX_STAT, 32'h0000_0001);
		bus(1'b1, IDX_STAT, 32'h0000_0001);
		`CHK(irq_o, 1'b0)
		bus(1'b1, IDX_MASK, 32'h0000_001e);
		fm_u.pulse(3, 2);
		repeat (3) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		rchk(IDX_STAT, 32'h0000_0001);
		bus(1'b1, IDX_STAT, 32'h0000_0001);
		bus(1'b1, IDX_MASK, 32'h0000_001f);
		fm_u.pulse(6, 150);
		rchk(IDX_IN0, 32'h0000_0040);
		rchk(IDX_STAT, 32'h0000_0000);
		for (int k = 0; k < 2; k++) begin
			fm_u.pulse(4, 2);
			@(posedge clk_i);
		end
		rchk(IDX_STAT, 32'h0000_0000);
		fm_u.pulse(4, 2);
		repeat (3) @(posedge clk_i);
		rchk(IDX_STAT, 32'h0000_0002);
		rchk(IDX_CNT + 8'h01, 32'h0000_0000);
		bus(1'b1, IDX_STAT, 32'h0000_0002);
		// Pulse shorter than the filter: only the latch can show it
		repeat (150) @(posedge clk_i);
		fm_u.pulse(5, 20);
		repeat (30) @(posedge clk_i);
		rchk(IDX_IN0, 32'h0000_0020);
		rchk(IDX_IN0, 32'h0000_0000);
	endtask : t_inputs
	task automatic t_timer();
		bus(1'b1, IDX_TPER, 32'h0000_0001);
		rchk(IDX_TPER, 32'h0000_0005);
		bus(1'b1, IDX_TPER, 32'h003f_ffff);
		rchk(IDX_TPER, 32'h0030_d2c0);
		bus(1'b1, IDX_TPER, 32'h0000_0005);
		bus(1'b1, IDX_TCTL, 32'h0000_0003);
		repeat (70) @(posedge clk_i);
		rchk(IDX_STAT, 32'h0000_0010);
		bus(1'b1, IDX_STAT, 32'h0000_0010);
		repeat (200) @(posedge clk_i);
		rchk(IDX_STAT, 32'h0000_0000);
		bus(1'b1, IDX_TCTL, 32'h0000_0001);
		repeat (70) @(posedge clk_i);
		rchk(IDX_STAT, 32'h0000_0010);
		bus(1'b1, IDX_STAT, 32'h0000_0010);
		repeat (40) @(posedge clk_i);
		rchk(IDX_STAT, 32'h0000_0010);
	endtask : t_timer
	////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (miscompares == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		rst_i = 1'b1;
		wb_q = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_basic();
		t_filter();
		t_inputs();
		t_timer();
		tally_and_finish();
	end
	// Watchdog well beyond the roughly 30k cycles the run needs
	initial begin
		repeat (60000) @(posedge clk_i);
		miscompares++;
		tally_and_finish();
	end
endmodule : plc_input_interrupt_timer_tb
`default_nettype wire
